// ### hw/rcd_regs.vh
// Register map, field layout, codes and reset values of the command dispatcher
// Contract
// - Commands execute one at a time in the order the host submits them.
// - Replies are posted in the order they arise inside the device.
// - Every command and reply begins with a 32-bit correlation tag.
// - Reply tag is copied unchanged from its command, never interpreted.
// - Eight slots 0 to 7; slot 0 is resident system, 1 to 7 assignable.
// - Command to a slot without subsystem returns nonzero error status.
// - Command with faulty data returns an error status.
// - Status zero on success, nonzero on any error.
// - Reply slot field equals the slot of the prompting command.
// - Command code is decoded relative to the addressed slot.
// - Any reset starts the init sequence with self-test first.
// - Failed self-test writes error state code and keeps detail word.
// - Passed self-test writes ready, lights LED, sets host alert, waits.
// - Host sets module alert; device clears it, then processes commands.
// - Failed phone sync disables the phone front end until re-init.
// - Good phone sync records identity for status replies, then enables.
// - Slot 0 code 0 is a memory load of the data block.
// - Load address is 16 times base plus offset; only offset advances.
// - Slot 0 code 1 jumps: offset to instruction pointer, base to segment.
// - Slot 0 code 4 is a status query answered with reply type 4.
`ifndef RCD_REGS_VH
`define RCD_REGS_VH

`define RCD_A_CSR 6'h00
`define RCD_A_CMD_TAG 6'h04
`define RCD_A_CMD_HDR 6'h08
`define RCD_A_CMD_ADDR 6'h0C
`define RCD_A_CMD_DATA 6'h10
`define RCD_A_CMD_GO 6'h14
`define RCD_A_RPL_TAG 6'h18
`define RCD_A_RPL_HDR 6'h1C
`define RCD_A_RPL_INFO 6'h20
`define RCD_A_RPL_MEM 6'h24
`define RCD_A_RPL_POP 6'h28
`define RCD_A_SLOT_MAP 6'h2C
`define RCD_A_TEST_DETAIL 6'h30

// Control register fields
`define RCD_CSR_HA 0
`define RCD_CSR_MA 1
`define RCD_CSR_MEM_EN 2
`define RCD_CSR_SOFT_RST 3
`define RCD_CSR_BANK_LO 4
`define RCD_CSR_BANK_HI 7

`define RCD_MS_TESTING 4'h0
`define RCD_MS_READY 4'h1
`define RCD_MS_RUNNING 4'h2
`define RCD_MS_ERR_BASE 4'h8

`define RCD_ST_OK 8'h00
`define RCD_ST_NO_SLOT 8'h01
`define RCD_ST_BAD_DATA 8'h02
`define RCD_ST_BAD_CODE 8'h03

// Slot 0 command codes and status reply type
`define RCD_OP_LOAD 8'h00
`define RCD_OP_JUMP 8'h01
`define RCD_OP_STATUS 8'h04
`define RCD_TYPE_STATUS 8'h04

`define RCD_PH_NORMAL 8'h00
`define RCD_PH_ABSENT 8'h01
`define RCD_PH_BROKEN 8'h02

// Reset values and load length limit
`define RCD_RST_BANK 4'h0
`define RCD_RST_SLOT_MAP 7'h00
`define RCD_MAX_LOAD_BYTES 3'h4

`endif

// ### hw/rcd_sync.v
// Two-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/100ps
module rcd_sync #(
    parameter W = 1
) (
    input wire pclk,
    input wire presetn,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ### hw/rcd_top.v
// Command dispatcher with init handshake and APB register access
`timescale 1ns/100ps
`include "rcd_regs.vh"
module rcd_top #(
    parameter [15:0] ROM_VERSION = 16'h0100,
    parameter [15:0] RAM_BASE_PARA = 16'h1000,
    parameter [15:0] RAM_SIZE_PARA = 16'h2000
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire selftest_done,
    input wire selftest_pass,
    input wire [2:0] selftest_code,
    input wire [31:0] selftest_detail,
    input wire phone_sync_done,
    input wire phone_sync_ok,
    input wire [7:0] phone_id,
    input wire sub_ack,
    input wire [7:0] sub_status,
    output reg selftest_start,
    output reg green_led,
    output reg phone_enable,
    output reg mem_we,
    output reg [19:0] mem_addr,
    output reg [7:0] mem_wdata,
    output reg cpu_jump,
    output reg [15:0] cpu_ip,
    output reg [15:0] cpu_cs,
    output reg sub_req,
    output reg [2:0] sub_slot,
    output reg [7:0] sub_code,
    output reg [31:0] sub_tag,
    output reg [31:0] sub_addr,
    output reg [31:0] sub_data
);
    localparam [4:0] I_TEST = 5'h01;
    localparam [4:0] I_FAIL = 5'h02;
    localparam [4:0] I_WAIT_HA = 5'h04;
    localparam [4:0] I_WAIT_MA = 5'h08;
    localparam [4:0] I_RUN = 5'h10;
    localparam [4:0] C_IDLE = 5'h01;
    localparam [4:0] C_EXEC = 5'h02;
    localparam [4:0] C_LOAD = 5'h04;
    localparam [4:0] C_SUB = 5'h08;
    localparam [4:0] C_POST = 5'h10;

    wire [4:0] st_sync;
    wire [9:0] ph_sync;
    wire [31:0] detail_sync;
    wire st_done_s = st_sync[0];
    wire st_pass_s = st_sync[1];
    wire [2:0] st_code_s = st_sync[4:2];
    wire ph_done_s = ph_sync[0];
    wire ph_ok_s = ph_sync[1];
    wire [7:0] ph_id_s = ph_sync[9:2];
    reg [31:0] detail_reg;

    rcd_sync #(.W(5)) u_sync_test (
        .pclk(pclk),
        .presetn(presetn),
        .d({selftest_code, selftest_pass, selftest_done}),
        .q(st_sync)
    );
    rcd_sync #(.W(32)) u_sync_detail (
        .pclk(pclk),
        .presetn(presetn),
        .d(selftest_detail),
        .q(detail_sync)
    );
    rcd_sync #(.W(10)) u_sync_phone (
        .pclk(pclk),
        .presetn(presetn),
        .d({phone_id, phone_sync_ok, phone_sync_done}),
        .q(ph_sync)
    );

    reg [4:0] init_reg;
    reg [4:0] cmd_reg;
    reg ha_reg;
    reg ma_reg;
    reg mem_en_reg;
    reg [3:0] bank_reg;
    reg [3:0] ms_reg;
    reg [6:0] slot_map_reg;
    reg [31:0] c_tag_reg;
    reg [2:0] c_slot_reg;
    reg [7:0] c_code_reg;
    reg [2:0] c_len_reg;
    reg [15:0] c_off_reg;
    reg [15:0] c_base_reg;
    reg [31:0] c_data_reg;
    reg [2:0] byte_cnt_reg;
    reg [7:0] res_status_reg;
    reg [7:0] res_type_reg;
    reg res_is_status_reg;
    reg rpl_valid_reg;
    reg [31:0] r_tag_reg;
    reg [31:0] r_hdr_reg;
    reg [31:0] r_info_reg;
    reg [31:0] r_mem_reg;
    reg jumped_reg;
    reg ph_pending_reg;
    reg [7:0] ph_status_reg;
    reg [7:0] ph_id_reg;

    wire [5:0] addr = paddr[5:0];
    wire setup = psel & ~penable;
    wire acc = psel & penable & pready & ~pslverr;
    wire wr = acc & pwrite;
    wire cmd_open = (init_reg == I_RUN) & (cmd_reg == C_IDLE);
    wire in_word = (paddr[31:6] == 26'h0000000) & (paddr[1:0] == 2'h0);
    wire soft_rst = wr & (addr == `RCD_A_CSR) & pwdata[`RCD_CSR_SOFT_RST];
    wire slot_live = (c_slot_reg == 3'h0) | slot_map_reg[c_slot_reg - 3'h1];
    wire [19:0] load_addr = {c_base_reg, 4'h0} + {4'h0, c_off_reg};
    wire [7:0] load_byte = c_data_reg[8*byte_cnt_reg +: 8];
    wire host_ma_set = wr & (addr == `RCD_A_CSR) & pwdata[`RCD_CSR_MA];
    wire host_ha_clr = wr & (addr == `RCD_A_CSR) & ~pwdata[`RCD_CSR_HA];
    wire post_now = (cmd_reg == C_POST) & ~rpl_valid_reg;
    wire ha_set = post_now | ((init_reg == I_TEST) & st_done_s);
    wire rpl_pop = wr & (addr == `RCD_A_RPL_POP);

    reg [31:0] rdata_next;
    reg err_next;

    // Read mux and refusal decode, sampled in the setup cycle
    always @* begin
        rdata_next = 32'h00000000;
        err_next = ~in_word;
        case (addr)
            `RCD_A_CSR: rdata_next = {16'h0000, jumped_reg, phone_enable,
                rpl_valid_reg, ~cmd_open, ms_reg, bank_reg, 1'b0,
                mem_en_reg, ma_reg, ha_reg};
            `RCD_A_CMD_TAG: rdata_next = c_tag_reg;
            `RCD_A_CMD_HDR: rdata_next = {13'h0000, c_len_reg, c_code_reg,
                5'h00, c_slot_reg};
            `RCD_A_CMD_ADDR: rdata_next = {c_base_reg, c_off_reg};
            `RCD_A_CMD_DATA: rdata_next = c_data_reg;
            `RCD_A_RPL_TAG: rdata_next = r_tag_reg;
            `RCD_A_RPL_HDR: rdata_next = r_hdr_reg;
            `RCD_A_RPL_INFO: rdata_next = r_info_reg;
            `RCD_A_RPL_MEM: rdata_next = r_mem_reg;
            `RCD_A_CMD_GO, `RCD_A_RPL_POP: rdata_next = 32'h00000000;
            `RCD_A_SLOT_MAP: rdata_next = {24'h000000, slot_map_reg, 1'b1};
            `RCD_A_TEST_DETAIL: rdata_next = detail_reg;
            default: err_next = 1'b1;
        endcase
        // Command fields locked while a command is in flight
        if (pwrite & ~cmd_open & ((addr == `RCD_A_CMD_TAG) |
            (addr == `RCD_A_CMD_HDR) | (addr == `RCD_A_CMD_ADDR) |
            (addr == `RCD_A_CMD_DATA) | (addr == `RCD_A_CMD_GO))) begin
            err_next = 1'b1;
        end
        if (pwrite & (addr == `RCD_A_RPL_POP) & ~rpl_valid_reg) begin
            err_next = 1'b1;
        end
    end

    // APB slave: no wait state, answer in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup & err_next;
            if (setup & ~pwrite) begin
                prdata <= err_next ? 32'h00000000 : rdata_next;
            end
        end
    end

    // Init sequence, control register and command engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_reg <= I_TEST;
            cmd_reg <= C_IDLE;
            ha_reg <= 1'b0;
            ma_reg <= 1'b0;
            mem_en_reg <= 1'b0;
            bank_reg <= `RCD_RST_BANK;
            ms_reg <= `RCD_MS_TESTING;
            slot_map_reg <= `RCD_RST_SLOT_MAP;
            selftest_start <= 1'b1;
            green_led <= 1'b0;
            phone_enable <= 1'b0;
            detail_reg <= 32'h00000000;
            c_tag_reg <= 32'h00000000;
            c_slot_reg <= 3'h0;
            c_code_reg <= 8'h00;
            c_len_reg <= 3'h0;
            c_off_reg <= 16'h0000;
            c_base_reg <= 16'h0000;
            c_data_reg <= 32'h00000000;
            byte_cnt_reg <= 3'h0;
            res_status_reg <= `RCD_ST_OK;
            res_type_reg <= 8'h00;
            res_is_status_reg <= 1'b0;
            rpl_valid_reg <= 1'b0;
            r_tag_reg <= 32'h00000000;
            r_hdr_reg <= 32'h00000000;
            r_info_reg <= 32'h00000000;
            r_mem_reg <= 32'h00000000;
            mem_we <= 1'b0;
            mem_addr <= 20'h00000;
            mem_wdata <= 8'h00;
            cpu_jump <= 1'b0;
            cpu_ip <= 16'h0000;
            cpu_cs <= 16'h0000;
            jumped_reg <= 1'b0;
            ph_pending_reg <= 1'b1;
            ph_status_reg <= `RCD_PH_ABSENT;
            ph_id_reg <= 8'h00;
            sub_req <= 1'b0;
            sub_slot <= 3'h0;
            sub_code <= 8'h00;
            sub_tag <= 32'h00000000;
            sub_addr <= 32'h00000000;
            sub_data <= 32'h00000000;
        end else if (soft_rst) begin
            init_reg <= I_TEST;
            cmd_reg <= C_IDLE;
            ha_reg <= 1'b0;
            ma_reg <= 1'b0;
            ms_reg <= `RCD_MS_TESTING;
            selftest_start <= 1'b1;
            green_led <= 1'b0;
            phone_enable <= 1'b0;
            rpl_valid_reg <= 1'b0;
            mem_we <= 1'b0;
            cpu_jump <= 1'b0;
            jumped_reg <= 1'b0;
            ph_pending_reg <= 1'b1;
            ph_status_reg <= `RCD_PH_ABSENT;
            sub_req <= 1'b0;
        end else begin
            selftest_start <= 1'b0;
            mem_we <= 1'b0;
            cpu_jump <= 1'b0;
            // Device set wins over a host clear in the same cycle
            if (ha_set) begin
                ha_reg <= 1'b1;
            end else if (host_ha_clr) begin
                ha_reg <= 1'b0;
            end
            if (wr & (addr == `RCD_A_CSR)) begin
                mem_en_reg <= pwdata[`RCD_CSR_MEM_EN];
                bank_reg <= pwdata[`RCD_CSR_BANK_HI:`RCD_CSR_BANK_LO];
            end
            if (wr & (addr == `RCD_A_SLOT_MAP)) begin
                slot_map_reg <= pwdata[7:1];
            end
            if (rpl_pop) begin
                rpl_valid_reg <= 1'b0;
            end
            if (wr & (addr == `RCD_A_CMD_TAG)) begin
                c_tag_reg <= pwdata;
            end
            if (wr & (addr == `RCD_A_CMD_HDR)) begin
                c_slot_reg <= pwdata[2:0];
                c_code_reg <= pwdata[15:8];
                c_len_reg <= pwdata[18:16];
            end
            if (wr & (addr == `RCD_A_CMD_ADDR)) begin
                c_off_reg <= pwdata[15:0];
                c_base_reg <= pwdata[31:16];
            end
            if (wr & (addr == `RCD_A_CMD_DATA)) begin
                c_data_reg <= pwdata;
            end
            // Host set of module alert wins over the device clear
            if (host_ma_set) begin
                ma_reg <= 1'b1;
            end else if (ma_reg & mem_en_reg &
                ((init_reg == I_WAIT_MA) | (init_reg == I_RUN))) begin
                ma_reg <= 1'b0;
            end
            case (init_reg)
                I_TEST: begin
                    if (st_done_s) begin
                        detail_reg <= detail_sync;
                        if (st_pass_s) begin
                            ms_reg <= `RCD_MS_READY;
                            green_led <= 1'b1;
                            init_reg <= I_WAIT_HA;
                        end else begin
                            ms_reg <= `RCD_MS_ERR_BASE |
                                {1'b0, st_code_s};
                            init_reg <= I_FAIL;
                        end
                    end
                end
                I_FAIL: init_reg <= I_FAIL;
                I_WAIT_HA: begin
                    if (~ha_reg) begin
                        init_reg <= I_WAIT_MA;
                    end
                end
                I_WAIT_MA: begin
                    if (ma_reg & mem_en_reg) begin
                        init_reg <= I_RUN;
                    end
                end
                I_RUN: init_reg <= I_RUN;
                default: init_reg <= I_TEST;
            endcase
            // Phone front end sync, only once microcode runs
            if (jumped_reg & ph_pending_reg & ph_done_s) begin
                ph_pending_reg <= 1'b0;
                if (ph_ok_s) begin
                    ph_id_reg <= ph_id_s;
                    ph_status_reg <= `RCD_PH_NORMAL;
                    phone_enable <= 1'b1;
                end else begin
                    ph_status_reg <= `RCD_PH_BROKEN;
                    phone_enable <= 1'b0;
                end
            end
            case (cmd_reg)
                C_IDLE: begin
                    if (wr & (addr == `RCD_A_CMD_GO)) begin
                        cmd_reg <= C_EXEC;
                    end
                end
                C_EXEC: begin
                    res_type_reg <= c_code_reg;
                    res_status_reg <= `RCD_ST_OK;
                    res_is_status_reg <= 1'b0;
                    cmd_reg <= C_POST;
                    byte_cnt_reg <= 3'h0;
                    if (!slot_live) begin
                        res_status_reg <= `RCD_ST_NO_SLOT;
                    end else if (c_slot_reg != 3'h0) begin
                        sub_req <= 1'b1;
                        sub_slot <= c_slot_reg;
                        sub_code <= c_code_reg;
                        sub_tag <= c_tag_reg;
                        sub_addr <= {c_base_reg, c_off_reg};
                        sub_data <= c_data_reg;
                        cmd_reg <= C_SUB;
                    end else if (c_code_reg == `RCD_OP_LOAD) begin
                        if ((c_len_reg == 3'h0) |
                            (c_len_reg > `RCD_MAX_LOAD_BYTES)) begin
                            res_status_reg <= `RCD_ST_BAD_DATA;
                        end else begin
                            cmd_reg <= C_LOAD;
                        end
                    end else if (c_code_reg == `RCD_OP_JUMP) begin
                        cpu_ip <= c_off_reg;
                        cpu_cs <= c_base_reg;
                        cpu_jump <= 1'b1;
                        jumped_reg <= 1'b1;
                        ms_reg <= `RCD_MS_RUNNING;
                    end else if (c_code_reg == `RCD_OP_STATUS) begin
                        res_type_reg <= `RCD_TYPE_STATUS;
                        res_is_status_reg <= 1'b1;
                    end else begin
                        res_status_reg <= `RCD_ST_BAD_CODE;
                    end
                end
                C_LOAD: begin
                    mem_we <= 1'b1;
                    mem_addr <= load_addr;
                    mem_wdata <= load_byte;
                    c_off_reg <= c_off_reg + 16'h0001;
                    byte_cnt_reg <= byte_cnt_reg + 3'h1;
                    if (byte_cnt_reg + 3'h1 == c_len_reg) begin
                        cmd_reg <= C_POST;
                    end
                end
                C_SUB: begin
                    if (sub_ack) begin
                        sub_req <= 1'b0;
                        res_status_reg <= sub_status;
                        cmd_reg <= C_POST;
                    end
                end
                C_POST: begin
                    // Single reply slot keeps replies in order
                    if (!rpl_valid_reg) begin
                        rpl_valid_reg <= 1'b1;
                        r_tag_reg <= c_tag_reg;
                        r_hdr_reg <= {1'b1, 7'h00, res_status_reg,
                            res_type_reg, 5'h00, c_slot_reg};
                        r_info_reg <= 32'h00000000;
                        r_mem_reg <= 32'h00000000;
                        if (res_is_status_reg) begin
                            r_info_reg <= {ph_status_reg, ph_id_reg,
                                ROM_VERSION};
                            if (!jumped_reg) begin
                                r_mem_reg <= {RAM_SIZE_PARA, RAM_BASE_PARA};
                            end
                        end
                        cmd_reg <= C_IDLE;
                    end
                end
                default: cmd_reg <= C_IDLE;
            endcase
        end
    end
endmodule

// ### bench/rcd_sva.sv
// Checker: port-level relations of the command dispatcher
`timescale 1ns/100ps
module rcd_sva (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire selftest_start,
    input wire green_led,
    input wire mem_we,
    input wire cpu_jump,
    input wire sub_req,
    input wire sub_ack,
    input wire [2:0] sub_slot,
    input wire [31:0] sub_tag
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_acked; sub_req && sub_ack; endsequence
    property p_ready_next; s_setup |=> pready; endproperty
    a_ready_next: assert property (p_ready_next) else $error("no pready");
    property p_ready_access; pready |-> psel && penable; endproperty
    a_ready_access: assert property (p_ready_access) else $error("stray pready");
    property p_start_pulse; selftest_start |=> !selftest_start; endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("long start");
    property p_sub_slot; sub_req |-> sub_slot != 3'h0; endproperty
    a_sub_slot: assert property (p_sub_slot)
        else $error("slot 0 to sub");
    property p_sub_hold;
        sub_req && !sub_ack |=>
            sub_req && $stable(sub_tag) && $stable(sub_slot);
    endproperty
    a_sub_hold: assert property (p_sub_hold)
        else $error("request moved");
    property p_sub_drop; s_acked |=> !sub_req [*2]; endproperty
    a_sub_drop: assert property (p_sub_drop)
        else $error("request kept");
    property p_jump_pulse; cpu_jump |=> !cpu_jump; endproperty
    a_jump_pulse: assert property (p_jump_pulse)
        else $error("long jump");
    property p_gate; (sub_req || mem_we || cpu_jump) |-> green_led; endproperty
    a_gate: assert property (p_gate)
        else $error("work before ready");
endmodule
bind rcd_top rcd_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .selftest_start(selftest_start),
    .green_led(green_led), .mem_we(mem_we), .cpu_jump(cpu_jump),
    .sub_req(sub_req), .sub_ack(sub_ack), .sub_slot(sub_slot),
    .sub_tag(sub_tag));

// ### bench/rcd_far.sv
// Far-side model: self-test, phone front end and subsystem responders
`timescale 1ns/100ps
module rcd_far #(
    parameter [7:0] PHONE_ID = 8'h5C
) (
    input wire pclk,
    input wire presetn,
    input wire selftest_start,
    input wire cpu_jump,
    input wire sub_req,
    input wire [2:0] sub_slot,
    input wire [7:0] ack_dly,
    output logic selftest_done,
    output logic selftest_pass,
    output logic [2:0] selftest_code,
    output logic [31:0] selftest_detail,
    output logic phone_sync_done,
    output logic phone_sync_ok,
    output logic [7:0] phone_id,
    output logic sub_ack,
    output logic [7:0] sub_status
);
    logic [7:0] cnt;
    wire fire = sub_req && !sub_ack && cnt >= ack_dly;
    assign selftest_code = 3'h0;
    assign selftest_detail = 32'h0;
    // Arbitrary identity value
    assign phone_id = PHONE_ID;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            selftest_done <= 1'b0;
            selftest_pass <= 1'b0;
            phone_sync_done <= 1'b0;
            phone_sync_ok <= 1'b0;
            sub_ack <= 1'b0;
            sub_status <= 8'h00;
            cnt <= 8'h00;
        end else begin
            selftest_done <= !selftest_start;
            selftest_pass <= !selftest_start;
            if (cpu_jump) begin
                phone_sync_done <= 1'b1;
                phone_sync_ok <= 1'b1;
            end
            cnt <= (sub_req && !sub_ack) ? cnt + 8'h01 : 8'h00;
            sub_ack <= fire;
            sub_status <= fire ? {5'h0A, sub_slot} : ~sub_status;
        end
    end
endmodule

// ### bench/rcd_bench.sv
// Testbench: APB-driven dispatcher scenarios
`timescale 1ns/100ps
`include "rcd_regs.vh"
module rcd_bench;
    localparam [15:0] RV = 16'h0100;
    localparam [15:0] RB = 16'h1000;
    localparam [15:0] RS = 16'h2000;
    localparam [7:0] PID = 8'h5C;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, perr;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q, rt, rh, ri, rm, jl;
    logic [31:0] sub_tag, sub_addr, sub_data, selftest_detail;
    logic pready, pslverr, selftest_done, selftest_pass, phone_sync_done;
    logic phone_sync_ok, sub_ack, selftest_start, green_led, phone_enable;
    logic mem_we, cpu_jump, sub_req;
    logic [2:0] selftest_code, sub_slot;
    logic [7:0] phone_id, sub_status, mem_wdata, sub_code, dly = 8'h0;
    logic [19:0] mem_addr;
    logic [15:0] cpu_ip, cpu_cs;
    logic [27:0] wl[$];
    int errors = 0, n_tests = 0, cyc = 0;
    rcd_top #(.ROM_VERSION(RV), .RAM_BASE_PARA(RB), .RAM_SIZE_PARA(RS)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .selftest_done(selftest_done),
        .selftest_pass(selftest_pass), .selftest_code(selftest_code),
        .selftest_detail(selftest_detail), .phone_sync_done(phone_sync_done),
        .phone_sync_ok(phone_sync_ok), .phone_id(phone_id), .sub_ack(sub_ack),
        .sub_status(sub_status), .selftest_start(selftest_start),
        .green_led(green_led), .phone_enable(phone_enable), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .cpu_jump(cpu_jump),
        .cpu_ip(cpu_ip), .cpu_cs(cpu_cs), .sub_req(sub_req),
        .sub_slot(sub_slot), .sub_code(sub_code), .sub_tag(sub_tag),
        .sub_addr(sub_addr), .sub_data(sub_data));
    rcd_far #(.PHONE_ID(PID)) far (.pclk(pclk), .presetn(presetn),
        .selftest_start(selftest_start), .cpu_jump(cpu_jump),
        .sub_req(sub_req), .sub_slot(sub_slot), .ack_dly(dly),
        .selftest_done(selftest_done), .selftest_pass(selftest_pass),
        .selftest_code(selftest_code), .selftest_detail(selftest_detail),
        .phone_sync_done(phone_sync_done), .phone_sync_ok(phone_sync_ok),
        .phone_id(phone_id), .sub_ack(sub_ack), .sub_status(sub_status));
    initial forever #50 pclk = ~pclk;
    task print_verdict;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (mem_we === 1'b1) wl.push_back({mem_addr, mem_wdata});
        if (cpu_jump === 1'b1) jl = {cpu_cs, cpu_ip};
        if (sub_ack === 1'b1) rt = sub_tag;
        if (cyc == 20000) begin
            errors++;
            print_verdict;
        end
    end
    task chk(input logic [31:0] g, e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [5:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {26'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function logic [31:0] hc(logic [2:0] n, logic [7:0] c, logic [2:0] s);
        hc = {13'h0, n, c, 5'h0, s};
    endfunction
    function logic [31:0] hx(logic [7:0] st, logic [7:0] ty, logic [2:0] s);
        hx = {1'b1, 7'h0, st, ty, 5'h0, s};
    endfunction
    task cmd(input logic [31:0] tag, hdr, adr, dat);
        apb(1'b1, `RCD_A_CMD_TAG, tag);
        apb(1'b1, `RCD_A_CMD_HDR, hdr);
        apb(1'b1, `RCD_A_CMD_ADDR, adr);
        apb(1'b1, `RCD_A_CMD_DATA, dat);
        apb(1'b1, `RCD_A_CMD_GO, 32'h0);
        do apb(1'b0, `RCD_A_CSR, 32'h0);
        while (q[13] !== 1'b1);
        apb(1'b0, `RCD_A_RPL_TAG, 32'h0);
        chk(q, tag);
        apb(1'b0, `RCD_A_RPL_HDR, 32'h0);
        rh = q;
        apb(1'b0, `RCD_A_RPL_INFO, 32'h0);
        ri = q;
        apb(1'b0, `RCD_A_RPL_MEM, 32'h0);
        rm = q;
        apb(1'b1, `RCD_A_RPL_POP, 32'h0);
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        do apb(1'b0, `RCD_A_CSR, 32'h0);
        while (q[0] !== 1'b1);
        chk(q & 32'h0F03, 32'h0101);
        chk({31'h0, green_led}, 32'h1);
        apb(1'b1, `RCD_A_CSR, 32'h0);
        apb(1'b0, `RCD_A_CSR, 32'h0);
        chk(q & 32'h1, 32'h0);
        apb(1'b1, `RCD_A_CSR, 32'h36);
        apb(1'b0, `RCD_A_CSR, 32'h0);
        chk(q & 32'h0FF7, 32'h0134);
        apb(1'b1, 6'h34, 32'h0);
        chk({31'h0, perr}, 32'h1);
        cmd(32'hA5A50001, hc(3'h0, `RCD_OP_STATUS, 3'h0), 32'h0, 32'h0);
        chk(rh, hx(`RCD_ST_OK, `RCD_TYPE_STATUS, 3'h0));
        chk(rm, {RS, RB});
        cmd(32'h0000BEEF, hc(3'h2, `RCD_OP_LOAD, 3'h0), 32'h12340010, 32'hC3A7);
        chk(rh, hx(`RCD_ST_OK, `RCD_OP_LOAD, 3'h0));
        chk({4'h0, wl[0]}, {4'h0, 20'h12350, 8'hA7});
        chk({4'h0, wl[1]}, {4'h0, 20'h12351, 8'hC3});
        cmd(32'h77770003, hc(3'h0, `RCD_OP_LOAD, 3'h0), 32'h0, 32'h0);
        chk(rh, hx(`RCD_ST_BAD_DATA, `RCD_OP_LOAD, 3'h0));
        cmd(32'h77770004, hc(3'h0, 8'h07, 3'h0), 32'h0, 32'h0);
        chk(rh, hx(`RCD_ST_BAD_CODE, 8'h07, 3'h0));
        cmd(32'h77770005, hc(3'h0, 8'h00, 3'h3), 32'h0, 32'h0);
        chk(rh, hx(`RCD_ST_NO_SLOT, 8'h00, 3'h3));
        chk(32'(wl.size()), 32'h2);
        apb(1'b1, `RCD_A_SLOT_MAP, 32'h08);
        apb(1'b0, `RCD_A_SLOT_MAP, 32'h0);
        chk(q & 32'hFF, 32'h09);
        cmd(32'h33330006, hc(3'h0, 8'h00, 3'h3), 32'h0, 32'h0);
        chk(rh, hx(8'h53, 8'h00, 3'h3));
        chk(rt, 32'h33330006);
        dly <= 8'h06;
        cmd(32'h33330007, hc(3'h0, 8'h04, 3'h3), 32'h0, 32'h0);
        chk(rh, hx(8'h53, 8'h04, 3'h3));
        cmd(32'h11110008, hc(3'h0, `RCD_OP_JUMP, 3'h0), 32'hABCD0100, 32'h0);
        chk(jl, 32'hABCD0100);
        apb(1'b0, `RCD_A_CSR, 32'h0);
        chk(q & 32'h8F00, 32'h8200);
        cmd(32'h11110009, hc(3'h0, `RCD_OP_STATUS, 3'h0), 32'h0, 32'h0);
        chk(ri, {8'h00, PID, RV});
        chk({31'h0, phone_enable}, 32'h1);
        chk(rm, 32'h0);
        print_verdict;
    end
endmodule
